// ### core/gpio_ports.sv
// three port groups with alternate-function pin routing
//
// Design decision made here: the plain strobed port.
`timescale 1ns/1ns
`default_nettype none
// How it works
// R1: after reset all pins are plain inputs, no alternate function.
// R2: direction bit 1 drives the pin from the latch, 0 makes it input.
// R3: data reads return pin levels; data writes only load the latch.
// R4: port a is eight bits, data at C0, direction at C1.
// R5: port a function select resets to zero; a 1 picks analog input.
// R6: a selected alternate function owns the pin whatever the direction.
// R7: port a pins 7..1 are analog channels matching the channel code.
// R8: port a pin 0 is event input when timer zero clock code is 111.
// R9: port a function bit 0 selects analog use of port b pin 0.
// R10: port b data C2, direction C3, function select CB reset zero.
// R11: port b pin 7 outputs timer two overflow, pin 6 feeds event one.
// R12: port b pin 5 outputs pwm one/compare one, pin 4 pwm/compare zero.
// R13: port b pins 3,2 feed external irqs one,zero; pin 1 buzzer out.
// R14: port b pin 0 is analog channel zero when selected and code 000.
// R15: port b function bit 0 makes pin 0 the analog reference only.
// R16: port c data at C4, direction at C5 resetting to zero.
// R17: port c functions follow the serial mode register fields.
// R18: port c pin 6 serial data out, pin 5 serial data in.
// R19: port c pin 4 drives serial clock, or takes it when select 11.
// R20: port c pin 3 ready input, or ready output when select 11.
// R21: an owning output function drives the pin instead of the latch.
module gpio_ports (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [gpio_pkg::ADDR_WIDTH-1:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  input wire logic [gpio_pkg::PORT_WIDTH-1:0] port_a_in_i,
  output logic [gpio_pkg::PORT_WIDTH-1:0] port_a_out_o,
  output logic [gpio_pkg::PORT_WIDTH-1:0] port_a_oe_o,
  input wire logic [gpio_pkg::PORT_WIDTH-1:0] port_b_in_i,
  output logic [gpio_pkg::PORT_WIDTH-1:0] port_b_out_o,
  output logic [gpio_pkg::PORT_WIDTH-1:0] port_b_oe_o,
  input wire logic [gpio_pkg::PORT_WIDTH-1:0] port_c_in_i,
  output logic [gpio_pkg::PORT_WIDTH-1:0] port_c_out_o,
  output logic [gpio_pkg::PORT_WIDTH-1:0] port_c_oe_o,
  input wire logic [2:0] converter_channel_code_i,
  input wire logic [2:0] timer_zero_clock_select_i,
  input wire logic [1:0] serial_pin_mode_i,
  input wire logic [1:0] serial_clock_select_i,
  input wire logic serial_ready_enable_i,
  input wire logic timer_two_overflow_out_i,
  input wire logic pulse_width_out_zero_i,
  input wire logic pulse_width_out_one_i,
  input wire logic pulse_width_mode_zero_i,
  input wire logic pulse_width_mode_one_i,
  input wire logic compare_out_zero_i,
  input wire logic compare_out_one_i,
  input wire logic buzzer_out_i,
  input wire logic serial_data_out_i,
  input wire logic serial_clock_out_i,
  input wire logic serial_ready_out_i,
  output logic [7:0] analog_select_o,
  output logic analog_reference_pin_o,
  output logic event_count_input_zero_o,
  output logic event_count_input_one_o,
  output logic external_irq_zero_o,
  output logic external_irq_one_o,
  output logic serial_data_in_o,
  output logic serial_clock_in_o,
  output logic serial_ready_in_o
);
  import gpio_pkg::*;

  localparam int W = PORT_WIDTH;

  // ***************
  // decoding
  // ***************
  function automatic logic hit(input logic [ADDR_WIDTH-1:0] addr,
                               input logic [7:0] offset);
    hit = (addr == offset);
  endfunction

  function automatic logic [W-1:0] wide(input logic [7:0] value);
    wide = W'(value);
  endfunction

  // ***************
  // registers
  // ***************
  logic [W-1:0] a_latch, a_dir, b_latch, b_dir, c_latch, c_dir;
  logic [W-1:0] a_func_q, b_func_q;
  logic [W-1:0] a_pin, b_pin, c_pin;
  logic [3*W-1:0] pins_sync;

  pin_sync #(.WIDTH(3 * W)) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .async_i({port_c_in_i, port_b_in_i, port_a_in_i}),
    .sync_o(pins_sync)
  );
  assign a_pin = pins_sync[W-1:0];
  assign b_pin = pins_sync[2*W-1:W];
  assign c_pin = pins_sync[3*W-1:2*W];

  // data at C0/C1, C2/C3, C4/C5; writes load latch only
  port_latch #(.WIDTH(W)) u_port_a (  // see R4
    .clk_i(clk_i),
    .rst_i(rst_i),
    .latch_wr_i(wr_i && hit(addr_i, PORT_A_DATA_OFFSET)),
    .dir_wr_i(wr_i && hit(addr_i, PORT_A_DIRECTION_OFFSET)),
    .wdata_i(W'(wdata_i)),
    .latch_o(a_latch),
    .dir_o(a_dir)
  );

  port_latch #(.WIDTH(W)) u_port_b (  // see R10
    .clk_i(clk_i),
    .rst_i(rst_i),
    .latch_wr_i(wr_i && hit(addr_i, PORT_B_DATA_OFFSET)),
    .dir_wr_i(wr_i && hit(addr_i, PORT_B_DIRECTION_OFFSET)),
    .wdata_i(W'(wdata_i)),
    .latch_o(b_latch),
    .dir_o(b_dir)
  );

  port_latch #(.WIDTH(W)) u_port_c (  // see R16
    .clk_i(clk_i),
    .rst_i(rst_i),
    .latch_wr_i(wr_i && hit(addr_i, PORT_C_DATA_OFFSET)),
    .dir_wr_i(wr_i && hit(addr_i, PORT_C_DIRECTION_OFFSET)),
    .wdata_i(W'(wdata_i)),
    .latch_o(c_latch),
    .dir_o(c_dir)
  );

  // function selects start at plain i/o
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      a_func_q <= wide(FUNCTION_RESET);  // see R1, R5
    end else if (wr_i && hit(addr_i, PORT_A_FUNCTION_OFFSET)) begin
      a_func_q <= W'(wdata_i);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      b_func_q <= wide(FUNCTION_RESET);  // see R10
    end else if (wr_i && hit(addr_i, PORT_B_FUNCTION_OFFSET)) begin
      b_func_q <= W'(wdata_i);
    end
  end

  // ***************
  // read port
  // ***************
  logic [7:0] rdata_d;

  always_comb begin
    rdata_d = UNMAPPED_READ;
    if (rd_i) begin
      case (addr_i)
        PORT_A_DATA_OFFSET: rdata_d = 8'(a_pin);  // see R3
        PORT_A_DIRECTION_OFFSET: rdata_d = 8'(a_dir);
        PORT_B_DATA_OFFSET: rdata_d = 8'(b_pin);  // see R3
        PORT_B_DIRECTION_OFFSET: rdata_d = 8'(b_dir);
        PORT_C_DATA_OFFSET: rdata_d = 8'(c_pin);  // see R3
        PORT_C_DIRECTION_OFFSET: rdata_d = 8'(c_dir);
        PORT_A_FUNCTION_OFFSET: rdata_d = 8'(a_func_q);
        PORT_B_FUNCTION_OFFSET: rdata_d = 8'(b_func_q);
        default: rdata_d = UNMAPPED_READ;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_o <= UNMAPPED_READ;
    end else begin
      rdata_o <= rdata_d;
    end
  end

  // ***************
  // pin routing
  // ***************
  logic [W-1:0] a_out_d, a_oe_d, b_out_d, b_oe_d, c_out_d, c_oe_d;
  logic [7:0] analog_d;
  logic reference_d, event_mode, serial_on, clock_external;

  assign event_mode = (timer_zero_clock_select_i == TIMER_ZERO_EVENT_CODE);
  assign serial_on = (serial_pin_mode_i != SERIAL_PINS_OFF);
  assign clock_external = (serial_clock_select_i == SERIAL_CLOCK_EXTERNAL);

  // port a: analog inputs above bit 0, event input on bit 0
  always_comb begin
    a_out_d = a_latch;
    a_oe_d = a_dir;  // see R2
    analog_d = 8'h00;
    for (int i = 1; i < 8; i++) begin
      if (a_func_q[i]) begin
        a_oe_d[i] = 1'b0;  // see R6
        analog_d[i] = (converter_channel_code_i == 3'(i));  // see R7
      end
    end
    if (event_mode) begin
      a_oe_d[0] = 1'b0;  // see R8
    end
    // bit 0 of port a select steers port b pin 0
    if (a_func_q[0] && !b_func_q[0]) begin
      analog_d[0] = (converter_channel_code_i == 3'h0);  // see R9, R14
    end
  end

  // port b: timer, pwm, irq, buzzer and reference pins
  always_comb begin
    b_out_d = b_latch;
    b_oe_d = b_dir;  // see R2
    reference_d = 1'b0;
    if (b_func_q[B_OVERFLOW_BIT]) begin
      b_out_d[B_OVERFLOW_BIT] = timer_two_overflow_out_i;  // see R11, R21
      b_oe_d[B_OVERFLOW_BIT] = 1'b1;
    end
    if (b_func_q[B_EVENT_BIT]) begin
      b_oe_d[B_EVENT_BIT] = 1'b0;  // see R11, R6
    end
    if (b_func_q[B_PWM_ONE_BIT]) begin
      b_out_d[B_PWM_ONE_BIT] = pulse_width_mode_one_i ?
        pulse_width_out_one_i : compare_out_one_i;  // see R12, R21
      b_oe_d[B_PWM_ONE_BIT] = 1'b1;
    end
    if (b_func_q[B_PWM_ZERO_BIT]) begin
      b_out_d[B_PWM_ZERO_BIT] = pulse_width_mode_zero_i ?
        pulse_width_out_zero_i : compare_out_zero_i;  // see R12, R21
      b_oe_d[B_PWM_ZERO_BIT] = 1'b1;
    end
    if (b_func_q[B_IRQ_ONE_BIT]) begin
      b_oe_d[B_IRQ_ONE_BIT] = 1'b0;  // see R13
    end
    if (b_func_q[B_IRQ_ZERO_BIT]) begin
      b_oe_d[B_IRQ_ZERO_BIT] = 1'b0;  // see R13
    end
    if (b_func_q[B_BUZZER_BIT]) begin
      b_out_d[B_BUZZER_BIT] = buzzer_out_i;  // see R13, R21
      b_oe_d[B_BUZZER_BIT] = 1'b1;
    end
    if (b_func_q[0]) begin
      b_oe_d[0] = 1'b0;  // see R15
      reference_d = 1'b1;
    end else if (a_func_q[0]) begin
      b_oe_d[0] = 1'b0;  // see R14
    end
  end

  // port c: serial pins follow the serial mode fields
  always_comb begin
    c_out_d = c_latch;
    c_oe_d = c_dir;  // see R2
    if (serial_pin_mode_i[0]) begin
      c_out_d[C_DATA_OUT_BIT] = serial_data_out_i;  // see R18, R21
      c_oe_d[C_DATA_OUT_BIT] = 1'b1;
    end
    if (serial_pin_mode_i[1]) begin
      c_oe_d[C_DATA_IN_BIT] = 1'b0;  // see R18
    end
    if (serial_on) begin
      c_out_d[C_CLOCK_BIT] = serial_clock_out_i;  // see R19, R17
      c_oe_d[C_CLOCK_BIT] = !clock_external;
    end
    if (serial_ready_enable_i) begin
      c_out_d[C_READY_BIT] = serial_ready_out_i;  // see R20, R21
      c_oe_d[C_READY_BIT] = clock_external;
    end
  end

  // pins and peripheral feeds all come from flops
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      port_a_out_o <= wide(LATCH_RESET);
      port_a_oe_o <= wide(DIRECTION_RESET);  // see R1
      port_b_out_o <= wide(LATCH_RESET);
      port_b_oe_o <= wide(DIRECTION_RESET);
      port_c_out_o <= wide(LATCH_RESET);
      port_c_oe_o <= wide(DIRECTION_RESET);
    end else begin
      port_a_out_o <= a_out_d;
      port_a_oe_o <= a_oe_d;
      port_b_out_o <= b_out_d;
      port_b_oe_o <= b_oe_d;
      port_c_out_o <= c_out_d;
      port_c_oe_o <= c_oe_d;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      analog_select_o <= 8'h00;
      analog_reference_pin_o <= 1'b0;
      event_count_input_zero_o <= 1'b0;
      event_count_input_one_o <= 1'b0;
      external_irq_zero_o <= 1'b0;
      external_irq_one_o <= 1'b0;
      serial_data_in_o <= 1'b0;
      serial_clock_in_o <= 1'b0;
      serial_ready_in_o <= 1'b0;
    end else begin
      analog_select_o <= analog_d;
      analog_reference_pin_o <= reference_d;
      event_count_input_zero_o <= event_mode && a_pin[0];  // see R8
      event_count_input_one_o <= b_func_q[B_EVENT_BIT] && b_pin[B_EVENT_BIT];
      external_irq_zero_o <= b_func_q[B_IRQ_ZERO_BIT] &&
        b_pin[B_IRQ_ZERO_BIT];  // see R13
      external_irq_one_o <= b_func_q[B_IRQ_ONE_BIT] && b_pin[B_IRQ_ONE_BIT];
      serial_data_in_o <= serial_pin_mode_i[1] && c_pin[C_DATA_IN_BIT];
      serial_clock_in_o <= serial_on && clock_external &&
        c_pin[C_CLOCK_BIT];  // see R19
      serial_ready_in_o <= serial_ready_enable_i && !clock_external &&
        c_pin[C_READY_BIT];  // see R20
    end
  end

  // ***************
  // checks
  // ***************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence latch_write_s;
    wr_i && hit(addr_i, PORT_A_DATA_OFFSET) ##1
      !(wr_i && hit(addr_i, PORT_A_DATA_OFFSET));
  endsequence

  reset_inputs_a: assert property (@(posedge clk_i) disable iff (1'b0)  // see R1
    rst_i |=> port_a_oe_o == '0 && port_b_oe_o == '0 && port_c_oe_o == '0)
    else $error("pin driven after reset");
  dir_drive_a: assert property (  // see R2
    a_dir[5] && !a_func_q[5] |=> port_a_oe_o[5] &&
      port_a_out_o[5] == $past(a_latch[5]))
    else $error("direction bit does not drive pin");
  pin_read_a: assert property (  // see R3
    rd_i && hit(addr_i, PORT_B_DATA_OFFSET) |=> rdata_o == $past(b_pin))
    else $error("data read not pin level");
  latch_pin_a: assert property (  // see R4
    latch_write_s |=> port_a_out_o == $past(wdata_i, 2))
    else $error("latch write not seen on pin");
  analog_chan_a: assert property (  // see R7
    a_func_q[3] && converter_channel_code_i == 3'h3 |=>
      analog_select_o[3] && !port_a_oe_o[3])
    else $error("analog channel not routed");
  event_input_a: assert property (  // see R8
    event_mode && a_pin[0] |=> event_count_input_zero_o && !port_a_oe_o[0])
    else $error("event input not routed");
  overflow_out_a: assert property (  // see R11
    b_func_q[B_OVERFLOW_BIT] |=> port_b_oe_o[B_OVERFLOW_BIT] &&
      port_b_out_o[B_OVERFLOW_BIT] == $past(timer_two_overflow_out_i))
    else $error("overflow not on pin");
  reference_pin_a: assert property (  // see R15
    b_func_q[0] |=> analog_reference_pin_o && !analog_select_o[0] &&
      !port_b_oe_o[0])
    else $error("reference pin misused");
  serial_clock_a: assert property (  // see R19
    serial_on && !clock_external |=> port_c_oe_o[C_CLOCK_BIT] &&
      port_c_out_o[C_CLOCK_BIT] == $past(serial_clock_out_i))
    else $error("serial clock not driven");
  ready_out_a: assert property (  // see R20
    serial_ready_enable_i && clock_external |=> port_c_oe_o[C_READY_BIT])
    else $error("ready output not driven");
endmodule
`default_nettype wire

// ### shared/gpio_pkg.sv
// constants shared by the port-group block and its helpers
package gpio_pkg;

  // ***************
  // widths
  // ***************
  localparam int PORT_WIDTH = 8;
  localparam int ADDR_WIDTH = 8;

  // ***************
  // register offsets
  // ***************
  localparam logic [7:0] PORT_A_DATA_OFFSET = 8'hC0;
  localparam logic [7:0] PORT_A_DIRECTION_OFFSET = 8'hC1;
  localparam logic [7:0] PORT_B_DATA_OFFSET = 8'hC2;
  localparam logic [7:0] PORT_B_DIRECTION_OFFSET = 8'hC3;
  localparam logic [7:0] PORT_C_DATA_OFFSET = 8'hC4;
  localparam logic [7:0] PORT_C_DIRECTION_OFFSET = 8'hC5;
  localparam logic [7:0] PORT_A_FUNCTION_OFFSET = 8'hCA;
  localparam logic [7:0] PORT_B_FUNCTION_OFFSET = 8'hCB;

  // ***************
  // values after reset
  // ***************
  localparam logic [7:0] LATCH_RESET = 8'h00;
  localparam logic [7:0] DIRECTION_RESET = 8'h00;
  localparam logic [7:0] FUNCTION_RESET = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // ***************
  // field codes
  // ***************
  localparam logic [2:0] TIMER_ZERO_EVENT_CODE = 3'h7;
  localparam logic [1:0] SERIAL_CLOCK_EXTERNAL = 2'h3;
  localparam logic [1:0] SERIAL_PINS_OFF = 2'h0;

  // ***************
  // pin positions
  // ***************
  localparam int B_OVERFLOW_BIT = 7;
  localparam int B_EVENT_BIT = 6;
  localparam int B_PWM_ONE_BIT = 5;
  localparam int B_PWM_ZERO_BIT = 4;
  localparam int B_IRQ_ONE_BIT = 3;
  localparam int B_IRQ_ZERO_BIT = 2;
  localparam int B_BUZZER_BIT = 1;
  localparam int C_DATA_OUT_BIT = 6;
  localparam int C_DATA_IN_BIT = 5;
  localparam int C_CLOCK_BIT = 4;
  localparam int C_READY_BIT = 3;

endpackage

// ### core/pin_sync.sv
// two-flop synchroniser for pin levels
`timescale 1ns/1ns
`default_nettype none
module pin_sync #(
  parameter int WIDTH = 8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_q <= '0;
      sync_o <= '0;
    end else begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end
endmodule
`default_nettype wire

// ### core/port_latch.sv
// output latch and direction register of one port group
`timescale 1ns/1ns
`default_nettype none
module port_latch #(
  parameter int WIDTH = 8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic latch_wr_i,
  input wire logic dir_wr_i,
  input wire logic [WIDTH-1:0] wdata_i,
  output logic [WIDTH-1:0] latch_o,
  output logic [WIDTH-1:0] dir_o
);
  import gpio_pkg::*;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      latch_o <= WIDTH'(LATCH_RESET);
    end else if (latch_wr_i) begin
      latch_o <= wdata_i;
    end
  end

  // cleared direction keeps every pin an input unless an output function owns it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dir_o <= WIDTH'(DIRECTION_RESET);
    end else if (dir_wr_i) begin
      dir_o <= wdata_i;
    end
  end
endmodule
`default_nettype wire

// ### bench/pin_partner.sv
// outside world of one port group: resolves device drive against pin drive
`timescale 1ns/1ns
`default_nettype none
module pin_partner (
  input wire logic clk_i,
  input wire logic [7:0] out_i,
  input wire logic [7:0] oe_i,
  input wire logic [7:0] ext_i,
  input wire logic [7:0] ext_en_i,
  output logic [7:0] pin_o
);
  logic [7:0] float_q = 8'h00;
  // a pin nobody drives keeps changing so a stale level never passes
  always_ff @(posedge clk_i) begin
    float_q <= ~float_q;
  end
  assign pin_o = (out_i & oe_i) | (ext_i & ext_en_i & ~oe_i)
               | (float_q & ~ext_en_i & ~oe_i);
endmodule
`default_nettype wire

// ### bench/gpio_ports_tb.sv
// self-checking bench for the three port groups
`timescale 1ns/1ns
`default_nettype none
module gpio_ports_tb;
  localparam logic [7:0] CFG [5] = '{8'hC1, 8'hC3, 8'hC5, 8'hCA, 8'hCB};
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr_s = 1'b0;
  logic rd_s = 1'b0;
  logic [7:0] rdata, asel;
  wire [2:0][7:0] outp, oe, pin;
  logic [2:0][7:0] ext = '0;
  logic [2:0] code = 3'h0;
  logic [2:0] tsel = 3'h0;
  logic [1:0] smode = 2'h0;
  logic [1:0] csel = 2'h0;
  logic rdy_en = 1'b0;
  logic [10:0] per = '0;
  logic aref, ev0, ev1, irq0, irq1, serial_data_in, sck_in, rdy_in;
  int error_cnt = 0;
  int n_tests = 0;

  always #50 clk_i = ~clk_i;

  gpio_ports i_gpio_ports (
    .clk_i(clk_i), .rst_i(rst_i), .addr_i(addr), .wdata_i(wdata),
    .wr_i(wr_s), .rd_i(rd_s), .rdata_o(rdata),
    .port_a_in_i(pin[0]), .port_a_out_o(outp[0]), .port_a_oe_o(oe[0]),
    .port_b_in_i(pin[1]), .port_b_out_o(outp[1]), .port_b_oe_o(oe[1]),
    .port_c_in_i(pin[2]), .port_c_out_o(outp[2]), .port_c_oe_o(oe[2]),
    .converter_channel_code_i(code), .timer_zero_clock_select_i(tsel),
    .serial_pin_mode_i(smode), .serial_clock_select_i(csel),
    .serial_ready_enable_i(rdy_en), .timer_two_overflow_out_i(per[0]),
    .pulse_width_out_zero_i(per[1]), .pulse_width_out_one_i(per[2]),
    .pulse_width_mode_zero_i(per[3]), .pulse_width_mode_one_i(per[4]),
    .compare_out_zero_i(per[5]), .compare_out_one_i(per[6]),
    .buzzer_out_i(per[7]), .serial_data_out_i(per[8]),
    .serial_clock_out_i(per[9]), .serial_ready_out_i(per[10]),
    .analog_select_o(asel), .analog_reference_pin_o(aref),
    .event_count_input_zero_o(ev0), .event_count_input_one_o(ev1),
    .external_irq_zero_o(irq0), .external_irq_one_o(irq1),
    .serial_data_in_o(serial_data_in), .serial_clock_in_o(sck_in),
    .serial_ready_in_o(rdy_in)
  );

  for (genvar g = 0; g < 3; g++) begin : gp
    pin_partner i_pin_partner (
      .clk_i(clk_i), .out_i(outp[g]), .oe_i(oe[g]), .ext_i(ext[g]),
      .ext_en_i(8'hFF), .pin_o(pin[g])
    );
  end

  // ***************
  // shared tasks
  // ***************
  task automatic check(input string what, input logic [7:0] got,
                       input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic give_verdict;
    if (error_cnt == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk_i);
    wr_s <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_i);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk_i);
    rd_s <= 1'b0;
    @(negedge clk_i);
    check("rdata", rdata, exp);
  endtask

  // oe flop, two sync flops and one output register before a feed moves
  task automatic settle;
    repeat (5) @(negedge clk_i);
  endtask

  // ***************
  // scenarios
  // ***************
  task automatic t_reset;
    settle;
    for (int g = 0; g < 3; g++) check("oe", oe[g], 8'h00);
    check("asel", asel, 8'h00);
    check("aref", {7'h0, aref}, 8'h00);
    for (int i = 0; i < 5; i++) rd_chk(CFG[i], 8'h00);
  endtask

  task automatic t_port;
    for (int g = 0; g < 3; g++) begin
      @(posedge clk_i);
      ext[g] <= 8'hA5;
      wr(8'hC0 + 8'(2 * g), 8'h3C);
      wr(8'hC1 + 8'(2 * g), 8'h0F);
      settle;
      check("oe", oe[g], 8'h0F);
      check("out", outp[g] & oe[g], 8'h0C);
      rd_chk(8'hC0 + 8'(2 * g), 8'hAC);
      rd_chk(8'hC1 + 8'(2 * g), 8'h0F);
      wr(8'hC1 + 8'(2 * g), 8'h00);
    end
  endtask

  task automatic t_func_a;
    wr(8'hC1, 8'hFF);
    wr(8'hCA, 8'hFE);
    rd_chk(8'hCA, 8'hFE);
    for (int c = 0; c < 8; c++) begin
      @(posedge clk_i);
      code <= 3'(c);
      settle;
      check("asel", asel, c == 0 ? 8'h00 : 8'(1 << c));
      check("oe a", oe[0], 8'h01);
    end
    wr(8'hCA, 8'h00);
  endtask

  task automatic t_event;
    @(posedge clk_i);
    ext[0] <= 8'h01;
    tsel <= 3'h7;
    settle;
    check("ev0", {7'h0, ev0}, 8'h01);
    check("oe a", oe[0], 8'hFE);
    @(posedge clk_i);
    tsel <= 3'h6;
    settle;
    check("ev0", {7'h0, ev0}, 8'h00);
    check("oe a", oe[0], 8'hFF);
  endtask

  task automatic t_analog_b;
    @(posedge clk_i);
    code <= 3'h0;
    wr(8'hC3, 8'hFF);
    wr(8'hCA, 8'h01);
    settle;
    check("asel", asel, 8'h01);
    check("oe b", oe[1], 8'hFE);
    check("oe a", oe[0], 8'hFF);
    @(posedge clk_i);
    code <= 3'h1;
    settle;
    check("asel", asel, 8'h00);
    wr(8'hCB, 8'h01);
    wr(8'hCA, 8'h00);
    settle;
    check("aref", {6'h0, asel[0], aref}, 8'h01);
    check("oe b", oe[1], 8'hFE);
    wr(8'hCB, 8'h00);
    settle;
    check("aref", {6'h0, asel[0], aref}, 8'h00);
    check("oe b", oe[1], 8'hFF);
  endtask

  task automatic t_func_b;
    wr(8'hC3, 8'h00);
    wr(8'hCB, 8'hFE);
    @(posedge clk_i);
    ext[1] <= 8'h4C;
    per[7:0] <= 8'h97;
    settle;
    check("oe b", oe[1], 8'hB2);
    check("out b", outp[1] & oe[1], 8'hA2);
    check("b ins", {5'h0, ev1, irq1, irq0}, 8'h07);
    @(posedge clk_i);
    ext[1] <= 8'hB3;
    per[7:0] <= 8'h6A;
    settle;
    check("out b", outp[1] & oe[1], 8'h30);
    check("b ins", {5'h0, ev1, irq1, irq0}, 8'h00);
    wr(8'hCB, 8'h00);
  endtask

  task automatic ser_case(input logic [1:0] m, input logic [1:0] k,
                          input logic r, input logic [7:0] eoe,
                          input logic [2:0] ein);
    @(posedge clk_i);
    smode <= m;
    csel <= k;
    rdy_en <= r;
    settle;
    check("oe c", oe[2], eoe);
    check("out c", outp[2] & oe[2], eoe);
    check("c ins", {5'h0, serial_data_in, sck_in, rdy_in}, {5'h0, ein});
  endtask

  task automatic t_serial;
    wr(8'hC4, 8'h00);
    @(posedge clk_i);
    ext[2] <= 8'hFF;
    per[10:8] <= 3'h7;
    ser_case(2'h1, 2'h0, 1'b0, 8'h50, 3'h0);
    ser_case(2'h2, 2'h3, 1'b1, 8'h08, 3'h6);
    ser_case(2'h3, 2'h2, 1'b1, 8'h50, 3'h5);
    ser_case(2'h0, 2'h0, 1'b1, 8'h00, 3'h1);
    ser_case(2'h0, 2'h3, 1'b0, 8'h00, 3'h0);
  endtask

  task automatic t_unmapped;
    wr(8'hC8, 8'hFF);
    rd_chk(8'hC8, 8'h00);
    rd_chk(8'hC1, 8'hFF);
  endtask

  initial begin
    repeat (20000) @(posedge clk_i);
    error_cnt++;
    give_verdict;
  end

  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    ext <= {8'hFF, 8'hFF, 8'hFF};
    t_reset;
    t_port;
    t_func_a;
    t_event;
    t_analog_b;
    t_func_b;
    t_serial;
    t_unmapped;
    give_verdict;
  end
endmodule
`default_nettype wire
